// file: verilog/sdram_command_and_mode_register.sv
/*
 Device-side command decoder of a DDR2-style SDRAM: mode register, bank rows,
 refresh counter, self refresh and a small burst data path with a scaled-down array.
 Assumes the memory controller drives all command pins synchronously to clock.
*/
`timescale 1ns/1ns
module sdram_command_and_mode_register import sdram_pkg::*; (
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                cke,
  input  wire logic                cs_n,
  input  wire logic                ras_n,
  input  wire logic                cas_n,
  input  wire logic                we_n,
  input  wire logic [`BA_W-1:0]    ba,
  input  wire logic [`ADDR_W-1:0]  addr,
  input  wire logic [`DATA_W-1:0]  wr_data,
  input  wire logic                write_byte_mask,
  output logic [`DATA_W-1:0]       rd_data,
  output logic                     rd_valid,
  output logic [`MODE_W-1:0]       operating_mode_setup,
  output logic [`BANKS-1:0]        bank_open,
  output logic [`ADDR_W-1:0]       refresh_row,
  output logic                     in_self_refresh,
  output logic                     dll_on,
  output logic                     dll_reset_pulse
);
  cmd_e cmd;
  logic accept;

  // Command decode; deselect and no-operation fall through to nothing
  always_comb begin
    if (cs_n) begin
      cmd = C_DESEL;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'b000:  cmd = C_LOAD;
        3'b001:  cmd = C_REFRESH;
        3'b010:  cmd = C_PRE;
        3'b011:  cmd = C_ACT;
        3'b100:  cmd = C_WRITE;
        3'b101:  cmd = C_READ;
        default: cmd = C_NOP;
      endcase
    end
  end

  logic sr_reg, sr_next;
  logic [`ADDR_W-1:0] ref_row_reg, ref_row_next;
  logic dll_on_reg, dll_on_next;

  // Clocked, selected commands outside self refresh are accepted; refresh skips this gate so it can enter self refresh
  assign accept = cke && !sr_reg;

  // Mode register group
  logic [`MODE_W-1:0] mode_reg, mode_next;
  logic [2:0]         posted_reg, posted_next;
  logic               dll_pulse_reg, dll_pulse_next;

  always_comb begin
    mode_next      = mode_reg;
    posted_next    = posted_reg;
    dll_pulse_next = mode_reg[`DLL_BIT];
    // The reset bit lives one cycle, then the pulse has been issued
    mode_next[`DLL_BIT] = 1'b0;
    if (accept && cmd == C_LOAD) begin
      case (ba[1:0])
        `MODE_SEL: mode_next   = {ba, addr};
        `EMR_SEL:  posted_next = addr[`POSTED_LSB +: 3];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_reg      <= `MODE_RESET;
      posted_reg    <= 3'h0;
      dll_pulse_reg <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      posted_reg    <= posted_next;
      dll_pulse_reg <= dll_pulse_next;
    end
  end

  // Refresh and self refresh group
  always_comb begin
    sr_next      = sr_reg;
    ref_row_next = ref_row_reg;
    if (sr_reg) begin
      // Exit on the first cycle that clock enable returns
      if (cke) begin
        sr_next = 1'b0;
      end
    end else if (cmd == C_REFRESH) begin
      ref_row_next = ref_row_reg + `ADDR_W'(1);
      if (!cke) begin
        sr_next = 1'b1;
      end
    end
    dll_on_next = !sr_next;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sr_reg      <= 1'b0;
      ref_row_reg <= '0;
      dll_on_reg  <= 1'b1;
    end else begin
      sr_reg      <= sr_next;
      ref_row_reg <= ref_row_next;
      dll_on_reg  <= dll_on_next;
    end
  end

  // Column commands pass the posted delay before the burst engine sees them
  col_cmd_s col_cmd, dly_cmd;
  always_comb begin
    col_cmd.valid    = accept && (cmd == C_READ || cmd == C_WRITE);
    col_cmd.write    = (cmd == C_WRITE);
    col_cmd.auto_pre = addr[`AUTO_PRE_BIT];
    col_cmd.bank     = ba[1:0];
    col_cmd.col      = addr[`COL_W-1:0];
  end

  posted_delay i_posted_delay (
    .clock   (clock),
    .rstn    (rstn),
    .cmd_in  (col_cmd),
    .delay   (posted_reg),
    .cmd_out (dly_cmd)
  );

  logic [`BANKS-1:0]      open_vec;
  logic [`BANKS-1:0]      idle_vec;
  logic [`BANKS-1:0][1:0] row_low;
  logic                   ap_stb_reg, ap_stb_next;
  logic [1:0]             ap_bank_reg, ap_bank_next;

  bank_tracker i_bank_tracker (
    .clock    (clock),
    .rstn     (rstn),
    .act_stb  (accept && cmd == C_ACT),
    .pre_stb  (accept && cmd == C_PRE),
    .pre_all  (addr[`AUTO_PRE_BIT]),
    .cmd_bank (ba[1:0]),
    .row_in   (addr[1:0]),
    .ap_stb   (ap_stb_reg),
    .ap_bank  (ap_bank_reg),
    .open_vec (open_vec),
    .idle_vec (idle_vec),
    .row_low  (row_low)
  );

  // Burst engine; a new column command takes over any burst in progress
  burst_e               bst_reg, bst_next;
  logic [2:0]           lat_reg, lat_next;
  logic [2:0]           beat_reg, beat_next;
  logic                 is_wr_reg, is_wr_next;
  logic                 ap_reg, ap_next;
  logic [1:0]           bank_reg, bank_next;
  logic [`COL_W-1:0]    col_reg, col_next;
  logic [`DATA_W-1:0]   rd_data_reg, rd_data_next;
  logic                 rd_valid_reg, rd_valid_next;
  logic [2:0]           rl, rl_eff;
  logic                 blen8;
  logic [2:0]           last_beat;
  logic [`COL_W-1:0]    col_idx;
  logic [7:0]           mem_idx;
  logic                 mem_we;
  logic [`DATA_W-1:0]   mem [`MEM_DEPTH];

  assign rl        = mode_reg[`RL_LSB +: 3];
  assign rl_eff    = (rl < `MIN_RL) ? `MIN_RL : rl;
  assign blen8     = (mode_reg[`BURST_LSB +: 3] == `BURST8_CODE);
  assign last_beat = blen8 ? 3'h7 : 3'h3;

  // Wrap inside the aligned block; upper bits pick the block
  always_comb begin
    if (blen8) begin
      col_idx = {col_reg[`COL_W-1:3], col_reg[2:0] + beat_reg};
    end else begin
      col_idx = {col_reg[`COL_W-1:2], col_reg[1:0] + beat_reg[1:0]};
    end
  end

  // Scaled array: two row bits, four column bits per bank
  assign mem_idx = {bank_reg, row_low[bank_reg], col_idx[3:0]};
  assign mem_we  = (bst_reg == B_RUN) && is_wr_reg && !write_byte_mask;

  always_comb begin
    bst_next      = bst_reg;
    lat_next      = lat_reg;
    beat_next     = beat_reg;
    is_wr_next    = is_wr_reg;
    ap_next       = ap_reg;
    bank_next     = bank_reg;
    col_next      = col_reg;
    ap_stb_next   = 1'b0;
    ap_bank_next  = ap_bank_reg;
    rd_valid_next = (bst_reg == B_RUN) && !is_wr_reg;
    rd_data_next  = rd_valid_next ? mem[mem_idx] : rd_data_reg;
    case (bst_reg)
      B_IDLE: ;
      B_WAIT: begin
        if (lat_reg == 3'h0) begin
          bst_next = B_RUN;
        end else begin
          lat_next = lat_reg - 3'h1;
        end
      end
      B_RUN: begin
        if (beat_reg == last_beat) begin
          bst_next     = B_IDLE;
          ap_stb_next  = ap_reg;
          ap_bank_next = bank_reg;
        end else begin
          beat_next = beat_reg + 3'h1;
        end
      end
      default: bst_next = B_IDLE;
    endcase
    if (dly_cmd.valid) begin
      bst_next   = B_WAIT;
      // Writes run one cycle ahead of reads
      lat_next   = dly_cmd.write ? rl_eff - 3'h3 : rl_eff - 3'h2;
      beat_next  = 3'h0;
      is_wr_next = dly_cmd.write;
      ap_next    = dly_cmd.auto_pre;
      bank_next  = dly_cmd.bank;
      col_next   = dly_cmd.col;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bst_reg      <= B_IDLE;
      lat_reg      <= 3'h0;
      beat_reg     <= 3'h0;
      is_wr_reg    <= 1'b0;
      ap_reg       <= 1'b0;
      bank_reg     <= 2'h0;
      col_reg      <= '0;
      ap_stb_reg   <= 1'b0;
      ap_bank_reg  <= 2'h0;
      rd_data_reg  <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      bst_reg      <= bst_next;
      lat_reg      <= lat_next;
      beat_reg     <= beat_next;
      is_wr_reg    <= is_wr_next;
      ap_reg       <= ap_next;
      bank_reg     <= bank_next;
      col_reg      <= col_next;
      ap_stb_reg   <= ap_stb_next;
      ap_bank_reg  <= ap_bank_next;
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // Array has no reset so mode loads and resets never disturb it
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_idx] <= wr_data;
    end
  end

  assign rd_data              = rd_data_reg;
  assign rd_valid             = rd_valid_reg;
  assign operating_mode_setup = mode_reg;
  assign bank_open            = open_vec;
  assign refresh_row          = ref_row_reg;
  assign in_self_refresh      = sr_reg;
  assign dll_on               = dll_on_reg;
  assign dll_reset_pulse      = dll_pulse_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_load_dll;
    accept && cmd == C_LOAD && ba[1:0] == `MODE_SEL && addr[`DLL_BIT];
  endsequence
  sequence s_self_clear;
    mode_reg[`DLL_BIT] ##1 (dll_pulse_reg && !mode_reg[`DLL_BIT]);
  endsequence

  chk_deselect_hold: assert property (cs_n |=> $stable(mode_reg[7:0]) && $stable(ref_row_reg))
    else $error("deselected cycle changed device state");
  chk_nop_hold: assert property (cmd == C_NOP |=> $stable(mode_reg[7:0]) && $stable(posted_reg))
    else $error("no-operation changed mode state");
  chk_mode_store: assert property (accept && cmd == C_LOAD && ba[1:0] == `MODE_SEL
    |=> mode_reg[7:0] == $past(addr[7:0]) && mode_reg[16:9] == $past({ba, addr[13:9]}))
    else $error("mode load did not store address value");
  chk_dll_clear: assert property (s_load_dll |=> s_self_clear)
    else $error("delay-loop reset bit did not self-clear");
  chk_act_opens: assert property (accept && cmd == C_ACT && ba[1:0] == 2'h2 && idle_vec[2]
    |=> bank_open[2])
    else $error("activate did not open bank");
  chk_pre_all: assert property (accept && cmd == C_PRE && addr[`AUTO_PRE_BIT]
    |=> bank_open == '0)
    else $error("precharge all left a bank open");
  chk_refresh_count: assert property (!sr_reg && cmd == C_REFRESH
    |=> refresh_row == $past(ref_row_reg) + `ADDR_W'(1))
    else $error("refresh counter did not advance");
  chk_self_refresh: assert property (!sr_reg && cmd == C_REFRESH && !cke
    |=> in_self_refresh && !dll_on)
    else $error("self refresh entry kept delay loop on");
  chk_burst_four: assert property ($rose(rd_valid) && !blen8 && bst_reg == B_RUN
    |-> rd_valid[*3])
    else $error("read burst of four cut short");
  // Data register loads at the third edge after the command, so it is seen one edge later
  chk_read_latency: assert property (col_cmd.valid && !col_cmd.write && posted_reg == 3'h0
    && rl_eff == 3'h3 ##1 !dly_cmd.valid[*2] |-> ##1 !rd_valid ##1 rd_valid)
    else $error("first read data not at programmed latency");
endmodule

// file: verilog/sdram_cfg.svh
/*
 Constants of the command decoder, mode register and bank timing.
 Assumes a single 10 MHz clock; times are converted to cycles here.
*/
`ifndef SDRAM_CFG_SVH
`define SDRAM_CFG_SVH
`define BANKS          4
`define ADDR_W         14
`define BA_W           3
`define MODE_W         17
`define DATA_W         8
`define COL_W          10
`define MEM_DEPTH      256
`define DELAY_STAGES   7
`define MODE_RESET     17'h00032
`define BURST_LSB      0
`define BURST4_CODE    3'h2
`define BURST8_CODE    3'h3
`define RL_LSB         4
`define MIN_RL         3'h3
`define DLL_BIT        8
`define AUTO_PRE_BIT   10
`define POSTED_LSB     3
`define MODE_SEL       2'h0
`define EMR_SEL        2'h1
`define CLK_PERIOD_NS  100
`define ROW_CLOSE_NS   15
`define ROW_CLOSE_CYC  ((`ROW_CLOSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: verilog/sdram_pkg.sv
/*
 Types shared by the command decoder, the posted-command delay and the bank tracker.
 Assumes sdram_cfg.svh is available on the include path.
*/
`include "sdram_cfg.svh"
package sdram_pkg;
  typedef enum logic [2:0] {C_DESEL, C_NOP, C_LOAD, C_REFRESH, C_PRE, C_ACT, C_WRITE, C_READ} cmd_e;
  typedef enum logic [1:0] {BK_IDLE, BK_OPEN, BK_CLOSING} bank_e;
  typedef enum logic [1:0] {B_IDLE, B_WAIT, B_RUN} burst_e;
  typedef struct packed {
    logic              valid;
    logic              write;
    logic              auto_pre;
    logic [1:0]        bank;
    logic [`COL_W-1:0] col;
  } col_cmd_s;
endpackage

// file: verilog/posted_delay.sv
/*
 Holds a column command back by the programmed posted delay (0 to 7 cycles).
 Assumes the delay value only changes while no column command is in flight.
*/
`timescale 1ns/1ns
module posted_delay import sdram_pkg::*; (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire col_cmd_s   cmd_in,
  input  wire logic [2:0] delay,
  output col_cmd_s        cmd_out
);
  col_cmd_s stage_reg  [`DELAY_STAGES];
  col_cmd_s stage_next [`DELAY_STAGES];

  always_comb begin
    stage_next[0] = cmd_in;
    for (int i = 1; i < `DELAY_STAGES; i++) begin
      stage_next[i] = stage_reg[i-1];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `DELAY_STAGES; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      stage_reg <= stage_next;
    end
  end

  // Zero delay passes the command straight through
  assign cmd_out = (delay == 3'h0) ? cmd_in : stage_reg[delay - 3'h1];

  chk_posted_two: assert property (@(posedge clock) disable iff (!rstn)
    cmd_in.valid && delay == 3'h2 |-> ##2 cmd_out.valid)
    else $error("posted command not released after two cycles");
endmodule

// file: verilog/bank_tracker.sv
/*
 Per-bank row state: open row, precharge timing, idle flags.
 Assumes strobes come from an already decoded and accepted command.
*/
`timescale 1ns/1ns
module bank_tracker import sdram_pkg::*; (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic                    act_stb,
  input  wire logic                    pre_stb,
  input  wire logic                    pre_all,
  input  wire logic [1:0]              cmd_bank,
  input  wire logic [1:0]              row_in,
  input  wire logic                    ap_stb,
  input  wire logic [1:0]              ap_bank,
  output logic [`BANKS-1:0]            open_vec,
  output logic [`BANKS-1:0]            idle_vec,
  output logic [`BANKS-1:0][1:0]       row_low
);
  localparam logic [3:0] CLOSE_CYC = 4'(`ROW_CLOSE_CYC);
  logic [`BANKS-1:0] pre_hit;

  for (genvar b = 0; b < `BANKS; b++) begin : g_bank
    bank_e      st_reg, st_next;
    logic [3:0] tmr_reg, tmr_next;
    logic [1:0] row_reg, row_next;

    // Auto precharge and explicit precharge share one path
    assign pre_hit[b] = (pre_stb && (pre_all || cmd_bank == 2'(b))) || (ap_stb && ap_bank == 2'(b));

    always_comb begin
      st_next  = st_reg;
      tmr_next = tmr_reg;
      row_next = row_reg;
      case (st_reg)
        BK_IDLE: begin
          if (act_stb && cmd_bank == 2'(b)) begin
            st_next  = BK_OPEN;
            row_next = row_in;
          end
        end
        BK_OPEN: ;
        BK_CLOSING: begin
          if (tmr_reg <= 4'h1) begin
            st_next = BK_IDLE;
          end else begin
            tmr_next = tmr_reg - 4'h1;
          end
        end
        default: st_next = BK_IDLE;
      endcase
      // Restarts the period even on an idle or closing bank
      if (pre_hit[b]) begin
        st_next  = BK_CLOSING;
        tmr_next = CLOSE_CYC;
      end
    end

    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        st_reg      <= BK_IDLE;
        tmr_reg     <= 4'h0;
        row_reg     <= 2'h0;
        open_vec[b] <= 1'b0;
        idle_vec[b] <= 1'b1;
      end else begin
        st_reg      <= st_next;
        tmr_reg     <= tmr_next;
        row_reg     <= row_next;
        open_vec[b] <= (st_next == BK_OPEN);
        idle_vec[b] <= (st_next == BK_IDLE);
      end
    end
    assign row_low[b] = row_reg;
  end

  chk_pre_restart: assert property (@(posedge clock) disable iff (!rstn)
    pre_hit[0] |=> !idle_vec[0] && !open_vec[0])
    else $error("precharge did not start closing bank 0");
endmodule

// file: sim/mem_ctrl_model.sv
/*
 Memory controller model driving command, address and write data pins.
 Assumes the device takes a command on each rising clock edge.
*/
`timescale 1ns/1ns
module mem_ctrl_model (
  input  wire logic   clock,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [13:0] addr,
  output logic [7:0]  wr_data,
  output logic        write_byte_mask
);
  logic [3:0] opened;

  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
    ba = 3'h0;
    addr = 14'h0000;
    wr_data = 8'h00;
    write_byte_mask = 1'b0;
    opened = 4'h0;
  end

  task automatic set_cke(input logic v);
    @(posedge clock);
    cke <= v;
  endtask

  // Pattern is {cs_n, ras_n, cas_n, we_n}; returns at the edge that takes it
  task automatic cmd(input logic [3:0] pat, input logic [2:0] b, input logic [13:0] a);
    @(posedge clock);
    {cs_n, ras_n, cas_n, we_n} <= pat;
    ba <= b;
    addr <= a;
    @(posedge clock);
    {cs_n, ras_n, cas_n, we_n} <= 4'hF;
    // Deselected lines toggle so a stale address never looks valid
    addr <= ~a;
  endtask

  task automatic act(input logic [1:0] b, input logic [13:0] row);
    cmd(4'h3, {1'b0, b}, row);
    opened[b] = 1'b1;
  endtask

  task automatic pre(input logic [1:0] b, input logic all);
    cmd(4'h2, {1'b0, b}, {3'h0, all, 10'h000});
    if (all)
      opened = 4'h0;
    else
      opened[b] = 1'b0;
  endtask

  // Loads and refreshes go out only with every bank closed
  task automatic idle_all();
    if (opened != 4'h0)
      pre(2'h0, 1'b1);
    repeat (2) @(posedge clock);
  endtask

  task automatic load(input logic [1:0] sel, input logic [13:0] v);
    idle_all();
    cmd(4'h0, {1'b0, sel}, v);  // Whole value, third bank line low
    repeat (2) @(posedge clock);  // Mode-set wait
  endtask

  task automatic col(input logic wr, input logic [1:0] b, input logic [13:0] a);
    if (!opened[b])
      act(b, 14'h0002);
    cmd({3'b010, ~wr}, {1'b0, b}, a);
    if (a[10])
      opened[b] = 1'b0;
  endtask

  // k is posted delay plus read latency; beats land from edge e+k-1
  task automatic beats(input int k, input int blen, input logic [7:0] base, input logic [7:0] msk);
    repeat (k - 2) @(posedge clock);
    for (int i = 0; i < blen; i++) begin
      wr_data <= base + 8'(i);
      write_byte_mask <= msk[i];
      @(posedge clock);
    end
    wr_data <= ~wr_data;
    write_byte_mask <= 1'b0;
  endtask
endmodule

// file: sim/sdram_command_and_mode_register_test.sv
/*
 Self-checking bench for the device-side command decoder and mode register.
 Assumes mem_ctrl_model drives every command input; one bank and row are mirrored.
*/
`timescale 1ns/1ns
`include "sdram_cfg.svh"
module sdram_command_and_mode_register_test;
  localparam int LIMIT = 3000;
  logic                clock, rstn, cke, cs_n, ras_n, cas_n, we_n, write_byte_mask;
  logic                rd_valid, in_self_refresh, dll_on, dll_reset_pulse;
  logic [`BA_W-1:0]    ba;
  logic [`ADDR_W-1:0]  addr, refresh_row;
  logic [`DATA_W-1:0]  wr_data, rd_data;
  logic [`MODE_W-1:0]  operating_mode_setup;
  logic [`BANKS-1:0]   bank_open;
  logic [7:0]          mirror [16];
  int                  n_fail = 0;
  int                  cmp_count = 0;

  mem_ctrl_model i_mem_ctrl_model (.clock(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .wr_data(wr_data), .write_byte_mask(write_byte_mask));

  sdram_command_and_mode_register i_sdram_command_and_mode_register (.clock(clock), .rstn(rstn),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .wr_data(wr_data), .write_byte_mask(write_byte_mask), .rd_data(rd_data), .rd_valid(rd_valid),
    .operating_mode_setup(operating_mode_setup), .bank_open(bank_open), .refresh_row(refresh_row),
    .in_self_refresh(in_self_refresh), .dll_on(dll_on), .dll_reset_pulse(dll_reset_pulse));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [3:0] wrap_col(input logic [3:0] c, input int blen, input int i);
    return (c & ~4'(blen - 1)) | ((c + 4'(i)) & 4'(blen - 1));
  endfunction

  // All data traffic goes to bank 1, row 2
  task automatic do_write(input logic [3:0] c, input logic ap, input int blen, input int k,
                          input logic [7:0] base, input logic [7:0] msk);
    i_mem_ctrl_model.col(1'b1, 2'h1, {3'h0, ap, 6'h00, c});
    for (int i = 0; i < blen; i++)
      if (!msk[i])
        mirror[wrap_col(c, blen, i)] = base + 8'(i);
    i_mem_ctrl_model.beats(k, blen, base, msk);
  endtask

  task automatic do_read(input logic [3:0] c, input logic ap, input int blen, input int k);
    i_mem_ctrl_model.col(1'b0, 2'h1, {3'h0, ap, 6'h00, c});
    repeat (k - 1) @(posedge clock);
    #1;
    chk(17'(rd_valid), 17'h0);
    for (int i = 0; i < blen; i++) begin
      @(posedge clock);
      #1;
      chk(17'(rd_valid), 17'h1);
      chk(17'(rd_data), 17'(mirror[wrap_col(c, blen, i)]));
    end
    @(posedge clock);
    #1;
    chk(17'(rd_valid), 17'h0);
  endtask

  task automatic t_reset();
    chk(operating_mode_setup, 17'h00032);
    chk(17'(bank_open), 17'h0);
    chk(17'(refresh_row), 17'h0);
    chk({15'h0, dll_on, in_self_refresh}, 17'h2);
  endtask

  // Nothing is open yet, so raw loads keep the idle-bank condition
  task automatic t_mode();
    i_mem_ctrl_model.cmd(4'h0, 3'h0, 14'h0133);
    #1;
    chk(operating_mode_setup, 17'h00133);
    @(posedge clock);
    #1;
    chk(operating_mode_setup, 17'h00033);
    chk(17'(dll_reset_pulse), 17'h1);
    @(posedge clock);
    #1;
    chk(17'(dll_reset_pulse), 17'h0);
    i_mem_ctrl_model.cmd(4'h0, 3'h2, 14'h0042);
    #1;
    chk(operating_mode_setup, 17'h00033);
    i_mem_ctrl_model.load(2'h0, 14'h0032);
    chk(operating_mode_setup, 17'h00032);
  endtask

  task automatic t_select();
    i_mem_ctrl_model.act(2'h1, 14'h0002);
    #1;
    chk(17'(bank_open), 17'h2);
    // Precharge-all pattern with chip select high must close nothing
    i_mem_ctrl_model.cmd(4'hA, 3'h1, 14'h0400);
    #1;
    chk(17'(bank_open), 17'h2);
    i_mem_ctrl_model.cmd(4'h7, 3'h1, 14'h0400);
    #1;
    chk(17'(bank_open), 17'h2);
  endtask

  task automatic t_bursts();
    do_write(4'h0, 1'b0, 4, 3, 8'h10, 8'h00);
    do_write(4'h1, 1'b0, 4, 3, 8'h20, 8'h02);
    do_read(4'h1, 1'b0, 4, 3);
    i_mem_ctrl_model.load(2'h0, 14'h0033);
    // Masked beats land on columns written earlier, so every read column is known
    do_write(4'h5, 1'b0, 8, 3, 8'h40, 8'h18);
    do_read(4'h5, 1'b0, 8, 3);
    i_mem_ctrl_model.load(2'h0, 14'h0032);
    do_read(4'h1, 1'b0, 4, 3);
  endtask

  task automatic t_latency();
    i_mem_ctrl_model.load(2'h0, 14'h0042);
    do_read(4'h2, 1'b0, 4, 4);
    i_mem_ctrl_model.load(2'h1, 14'h0010);
    do_write(4'h4, 1'b0, 4, 6, 8'h60, 8'h00);
    do_read(4'h4, 1'b0, 4, 6);
    i_mem_ctrl_model.load(2'h1, 14'h0000);
    i_mem_ctrl_model.load(2'h0, 14'h0032);
  endtask

  task automatic t_autopre();
    do_read(4'h0, 1'b1, 4, 3);
    @(posedge clock);
    #1;
    chk(17'(bank_open), 17'h0);
    do_write(4'h2, 1'b1, 4, 3, 8'h70, 8'h00);
    repeat (3) @(posedge clock);
    #1;
    chk(17'(bank_open), 17'h0);
    do_read(4'h2, 1'b0, 4, 3);
  endtask

  task automatic t_precharge();
    i_mem_ctrl_model.act(2'h0, 14'h0001);
    #1;
    chk(17'(bank_open), 17'h3);
    i_mem_ctrl_model.pre(2'h0, 1'b0);
    #1;
    chk(17'(bank_open), 17'h2);
    i_mem_ctrl_model.pre(2'h1, 1'b0);
    i_mem_ctrl_model.pre(2'h1, 1'b0);
    #1;
    chk(17'(bank_open), 17'h0);
    repeat (2) @(posedge clock);
    i_mem_ctrl_model.act(2'h1, 14'h0002);
    i_mem_ctrl_model.act(2'h2, 14'h0003);
    #1;
    chk(17'(bank_open), 17'h6);
    i_mem_ctrl_model.pre(2'h0, 1'b1);
    #1;
    chk(17'(bank_open), 17'h0);
  endtask

  task automatic t_refresh();
    i_mem_ctrl_model.idle_all();
    i_mem_ctrl_model.cmd(4'h1, 3'h7, 14'h3FFF);
    #1;
    chk(17'(refresh_row), 17'h1);
    i_mem_ctrl_model.cmd(4'h1, 3'h0, 14'h0000);
    #1;
    chk(17'(refresh_row), 17'h2);
    i_mem_ctrl_model.set_cke(1'b0);
    i_mem_ctrl_model.cmd(4'h1, 3'h0, 14'h0000);
    #1;
    chk({15'h0, dll_on, in_self_refresh}, 17'h1);
    i_mem_ctrl_model.cmd(4'h3, 3'h3, 14'h0001);
    #1;
    chk(17'(bank_open), 17'h0);
    i_mem_ctrl_model.set_cke(1'b1);
    @(posedge clock);
    #1;
    chk({15'h0, dll_on, in_self_refresh}, 17'h2);
    i_mem_ctrl_model.act(2'h3, 14'h0001);
    #1;
    chk(17'(bank_open), 17'h8);
  endtask

  initial begin
    rstn = 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_mode();
    t_select();
    t_bursts();
    t_latency();
    t_autopre();
    t_precharge();
    t_refresh();
    wrap_up();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    #(LIMIT * 100);
    n_fail++;
    wrap_up();
  end
endmodule
